/* File: hdl/fmeh_fan_monitor.sv */
`timescale 1ns/10ps
// Summary of operation
// - summary reads no warning, fan combination, undefined event or not available
// - each fan reads OK, Warning on low speed or hours, Error below 400 rpm
// - one hour counter per fan, zero up to 500000 hours
// - measured speed of each fan readable as 16-bit rpm
// - hours against default or 1..65535 limit raise the feedback fault
// - self-test start accepted only while the starter is stopped
// - self-test forces all fans on for 40 seconds, no abort
// - after forced run classify speed as OK, Warning or Error
// - after switching fans off flag any fan that keeps turning
// - test result holds low speed, not stopping, no speed per fan
// - every new test run clears all result flags
// - a per-fan command clears that fan's hour counter
// - fault source: none, pin high, pin low, or command-word bit
// - ignore raises warning only; configured stop stops motor and warns
// - freewheel, the default, faults at once and lets the motor coast
// - decel or braking stops the motor first, then faults
// - fault warning shows only when mapped to a warning group
// - auto reset enable, off by default, recovers once cause clears
// - with auto reset on and cause gone, leave fault state
// - fault relay stays inactive while auto attempts run
// - failed auto attempts keep fault state and assert the relay
// - after the time limit only manual reset works; 5 min to unlimited
module fmeh_fan_monitor
  import fmeh_pkg::*;
#(
  parameter logic [CNT_W-1:0] TEST_CYC   = CNT_W'(TEST_CYCLES),
  parameter logic [CNT_W-1:0] STOP_CYC   = CNT_W'(STOP_CYCLES),
  parameter logic [CNT_W-1:0] HOUR_CYC   = CNT_W'(HOUR_CYCLES),
  parameter logic [CNT_W-1:0] MINUTE_CYC = CNT_W'(MINUTE_CYCLES)
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWe,
  input  wire logic        regRe,
  output logic      [31:0] regRdata,
  // fans
  input  wire logic [15:0] fanOneRpm,
  input  wire logic [15:0] fanTwoRpm,
  input  wire logic [15:0] fanThreeRpm,
  input  wire logic        fanDemand,
  output logic             fanForceOn,
  output logic             fanFeedbackFault,
  // starter and fault inputs
  input  wire logic        starterStopped,
  input  wire logic        extFaultPin,
  input  wire logic        extFaultCmdBit,
  input  wire logic        stopDone,
  input  wire logic        manualReset,
  // responses
  output logic      [2:0]  stopType,
  output logic             faultRelay,
  output logic             extFaultWarnVisible
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic [15:0]       rpm [3];
  logic [18:0]       hours [3];
  logic [1:0]        cond [3];
  logic [2:0]        eventMask;
  logic [2:0]        hoursReached;
  logic [2:0]        clearHours;
  logic [CFG_W-1:0]  cfg_r;
  logic [15:0]       hoursLimit_r;
  logic [18:0]       limitHours;
  logic [1:0]        cfgSrc;
  logic [2:0]        cfgResp;
  logic [2:0]        cfgLimit;
  logic              cfgAuto;
  logic              cfgMapped;
  logic              wrCtrl;
  logic              startReq;
  logic              startAccepted;
  fmeh_test_t        testState_r;
  logic [CNT_W-1:0]  testCnt_r;
  logic              evalSpeed;
  logic              evalStop;
  logic [8:0]        testFlags_r;
  logic              evalDone_r;
  logic [5:0]        cond_r;
  logic [3:0]        summary_r;
  logic [3:0]        summary_nxt;
  logic              pinMeta_r;
  logic              pinSync_r;
  logic              cause;
  fmeh_ext_t         exState_r;
  logic [CNT_W-1:0]  minCnt_r;
  logic [7:0]        minutes_r;
  logic              expired;
  logic              extWarn;
  logic              fanForceOn_r;
  logic              fanFeedbackFault_r;
  logic [2:0]        stopType_r;
  logic              faultRelay_r;
  logic              extWarnVis_r;
  logic [31:0]       regRdata_r;

  assign rpm[0] = fanOneRpm;
  assign rpm[1] = fanTwoRpm;
  assign rpm[2] = fanThreeRpm;

  assign cfgSrc    = cfg_r[CFG_SRC_POS +: 2];
  assign cfgResp   = cfg_r[CFG_RESP_POS +: 3];
  assign cfgAuto   = cfg_r[CFG_AUTO_POS];
  assign cfgLimit  = cfg_r[CFG_LIMIT_POS +: 3];
  assign cfgMapped = cfg_r[CFG_MAP_POS];

  assign wrCtrl        = regWe && regAddr == OFS_CTRL;
  assign startReq      = wrCtrl && regWdata[CTRL_START_POS];
  assign startAccepted = startReq && starterStopped && testState_r == ST_IDLE;

  // zero selects the default threshold
  assign limitHours = {3'h0, (hoursLimit_r == 16'h0) ? HOURS_LIMIT_DFLT : hoursLimit_r};

  // per-fan counters, live condition
  for (genvar g = 0; g < 3; g++) begin : gFan
    assign clearHours[g]   = wrCtrl && regWdata[CTRL_CLR_POS + g];
    assign hoursReached[g] = hours[g] >= limitHours;

    fmeh_fan_hours #(.HOUR_CYC(HOUR_CYC)) uHours (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .running  (rpm[g] > RPM_STOP_LIMIT),
      .clearReq (clearHours[g]),
      .hours    (hours[g])
    );

    always_comb begin
      if ((fanDemand || fanForceOn_r) && rpm[g] < RPM_MIN_LIMIT) begin
        cond[g] = COND_ERROR;
      end else if (((fanDemand || fanForceOn_r) && rpm[g] < RPM_NORMAL_LIMIT) ||
                   hoursReached[g]) begin
        cond[g] = COND_WARN;
      end else begin
        cond[g] = COND_OK;
      end
    end
    assign eventMask[g] = cond[g] != COND_OK;
  end

  // register writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_r        <= CFG_RESET;
      hoursLimit_r <= 16'h0;
    end else if (regWe && regAddr == OFS_CFG) begin
      cfg_r <= regWdata[CFG_W-1:0];
    end else if (regWe && regAddr == OFS_HLIMIT) begin
      hoursLimit_r <= regWdata[15:0];
    end
  end

  // self-test sequence
  assign evalSpeed = testState_r == ST_RUN && testCnt_r == TEST_CYC - CNT_W'(1);
  assign evalStop  = testState_r == ST_STOP && testCnt_r == STOP_CYC - CNT_W'(1);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      testState_r  <= ST_IDLE;
      testCnt_r    <= '0;
      fanForceOn_r <= 1'b0;
    end else begin
      case (testState_r)
        ST_IDLE: begin
          testCnt_r <= '0;
          if (startAccepted) begin
            testState_r  <= ST_RUN;
            fanForceOn_r <= 1'b1;
          end
        end
        ST_RUN: begin
          testCnt_r <= testCnt_r + CNT_W'(1);
          if (evalSpeed) begin
            testState_r  <= ST_STOP;
            testCnt_r    <= '0;
            fanForceOn_r <= 1'b0;
          end
        end
        ST_STOP: begin
          testCnt_r <= testCnt_r + CNT_W'(1);
          if (evalStop) begin
            testState_r <= ST_IDLE;
          end
        end
        default: begin
          testState_r  <= ST_IDLE;
          fanForceOn_r <= 1'b0;
        end
      endcase
    end
  end

  // result flags: low speed, not stopping, no speed
  always_ff @(posedge clk_sys) begin
    if (rst || startAccepted) begin
      testFlags_r <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (evalSpeed) begin
          testFlags_r[3*i]   <= rpm[i] >= RPM_MIN_LIMIT && rpm[i] < RPM_NORMAL_LIMIT;
          testFlags_r[3*i+2] <= rpm[i] < RPM_MIN_LIMIT;
        end
        if (evalStop && rpm[i] > RPM_STOP_LIMIT) begin
          testFlags_r[3*i+1] <= 1'b1;
        end
      end
    end
  end

  // summary and conditions
  always_comb begin
    if (!evalDone_r) begin
      summary_nxt = SUM_NA;
    end else if (testState_r != ST_IDLE) begin
      summary_nxt = SUM_UNDEF;
    end else begin
      summary_nxt = {1'b0, eventMask};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evalDone_r         <= 1'b0;
      summary_r          <= SUM_NA;
      cond_r             <= '0;
      fanFeedbackFault_r <= 1'b0;
    end else begin
      evalDone_r         <= evalDone_r || fanDemand || evalSpeed;
      summary_r          <= summary_nxt;
      cond_r             <= {cond[2], cond[1], cond[0]};
      fanFeedbackFault_r <= |hoursReached;
    end
  end

  // pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pinMeta_r <= 1'b0;
      pinSync_r <= 1'b0;
    end else begin
      pinMeta_r <= extFaultPin;
      pinSync_r <= pinMeta_r;
    end
  end

  // cause selection; active-high pin reads a broken cable as healthy
  always_comb begin
    case (cfgSrc)
      SRC_DI_HIGH: cause = pinSync_r;
      SRC_DI_LOW:  cause = !pinSync_r;
      SRC_VIRTUAL: cause = extFaultCmdBit;
      default:     cause = 1'b0;
    endcase
  end

  assign expired = cfgLimit < LIMIT_UNLIMITED && minutes_r >= LIMIT_MINUTES[cfgLimit];
  assign extWarn = cause && (cfgResp == RESP_IGNORE || cfgResp == RESP_CONFIG);

  // external fault response and recovery
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      exState_r  <= EX_IDLE;
      stopType_r <= STOP_NONE;
    end else begin
      case (exState_r)
        EX_IDLE: begin
          stopType_r <= (cause && cfgResp == RESP_CONFIG) ? STOP_CONFIG : STOP_NONE;
          if (cause && cfgResp == RESP_FREEWHEEL) begin
            exState_r  <= EX_FAULT;
            stopType_r <= STOP_FREEWHEEL;
          end else if (cause && (cfgResp == RESP_DECEL || cfgResp == RESP_BRAKE)) begin
            exState_r  <= EX_STOPPING;
            stopType_r <= (cfgResp == RESP_DECEL) ? STOP_DECEL : STOP_BRAKE;
          end
        end
        EX_STOPPING: begin
          if (stopDone) begin
            exState_r <= EX_FAULT;
          end
        end
        EX_FAULT: begin
          if (!cause && ((cfgAuto && !expired) || manualReset)) begin
            exState_r  <= EX_IDLE;
            stopType_r <= STOP_NONE;
          end else if (cfgAuto && expired) begin
            exState_r <= EX_LOCKED;
          end
        end
        EX_LOCKED: begin
          if (!cause && manualReset) begin
            exState_r  <= EX_IDLE;
            stopType_r <= STOP_NONE;
          end
        end
        default: begin
          exState_r  <= EX_IDLE;
          stopType_r <= STOP_NONE;
        end
      endcase
    end
  end

  // minutes spent in fault
  always_ff @(posedge clk_sys) begin
    if (rst || exState_r != EX_FAULT) begin
      minCnt_r  <= '0;
      minutes_r <= 8'h0;
    end else if (minCnt_r == MINUTE_CYC - CNT_W'(1)) begin
      minCnt_r  <= '0;
      minutes_r <= (minutes_r == 8'hff) ? minutes_r : minutes_r + 8'h1;
    end else begin
      minCnt_r <= minCnt_r + CNT_W'(1);
    end
  end

  // relay held off while auto attempts are still possible
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      faultRelay_r <= 1'b0;
      extWarnVis_r <= 1'b0;
    end else begin
      faultRelay_r <= exState_r == EX_LOCKED ||
                      (exState_r == EX_FAULT && !(cfgAuto && !expired));
      extWarnVis_r <= extWarn && cfgMapped;
    end
  end

  // register reads, one cycle later, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (rst || !regRe) begin
      regRdata_r <= 32'h0;
    end else begin
      case (regAddr)
        OFS_CFG:        regRdata_r <= {22'h0, cfg_r};
        OFS_HLIMIT:     regRdata_r <= {16'h0, hoursLimit_r};
        OFS_SUMMARY:    regRdata_r <= {28'h0, summary_r};
        OFS_COND:       regRdata_r <= {26'h0, cond_r};
        OFS_TEST:       regRdata_r <= {22'h0, testState_r != ST_IDLE, testFlags_r};
        OFS_HOURS0:     regRdata_r <= {13'h0, hours[0]};
        OFS_HOURS0 + 8'h4: regRdata_r <= {13'h0, hours[1]};
        OFS_HOURS0 + 8'h8: regRdata_r <= {13'h0, hours[2]};
        OFS_RPM0:       regRdata_r <= {16'h0, rpm[0]};
        OFS_RPM0 + 8'h4:   regRdata_r <= {16'h0, rpm[1]};
        OFS_RPM0 + 8'h8:   regRdata_r <= {16'h0, rpm[2]};
        OFS_STATUS:     regRdata_r <= {27'h0, exState_r == EX_LOCKED, faultRelay_r,
                                       extWarn, exState_r == EX_FAULT, fanFeedbackFault_r};
        default:        regRdata_r <= 32'h0;
      endcase
    end
  end

  assign regRdata            = regRdata_r;
  assign fanForceOn          = fanForceOn_r;
  assign fanFeedbackFault    = fanFeedbackFault_r;
  assign stopType            = stopType_r;
  assign faultRelay          = faultRelay_r;
  assign extFaultWarnVisible = extWarnVis_r;

  sequence sTestStart;
    startAccepted;
  endsequence

  sequence sForcedRun;
    fanForceOn_r [*8];
  endsequence

  chk_test_gate: assert property (
    testState_r == ST_IDLE && startReq && !starterStopped |=> testState_r == ST_IDLE)
    else $error("test started outside stop mode");

  chk_forced_run: assert property (sTestStart |=> sForcedRun)
    else $error("fans not forced on during test");

  chk_test_clear: assert property (sTestStart |=> testFlags_r == 9'h0)
    else $error("test flags not cleared at start");

  chk_summary_na: assert property (!evalDone_r |=> summary_r == SUM_NA)
    else $error("summary not unavailable before evaluation");

  chk_freewheel_fault: assert property (
    exState_r == EX_IDLE && cause && cfgResp == RESP_FREEWHEEL
    |=> exState_r == EX_FAULT && stopType_r == STOP_FREEWHEEL)
    else $error("freewheel response did not fault at once");

  chk_decel_wait: assert property (
    exState_r == EX_STOPPING && !stopDone |=> exState_r == EX_STOPPING)
    else $error("fault raised before stop finished");

  chk_auto_leave: assert property (
    exState_r == EX_FAULT && cfgAuto && !expired && !cause |=> exState_r == EX_IDLE)
    else $error("auto reset did not leave fault");

  chk_relay_quiet: assert property (
    exState_r == EX_FAULT && cfgAuto && !expired |=> !faultRelay_r)
    else $error("relay active during auto attempts");

  chk_relay_locked: assert property (exState_r == EX_LOCKED |=> faultRelay_r)
    else $error("relay inactive after failed auto reset");

  chk_warn_map: assert property (extWarnVis_r |-> $past(extWarn) && $past(cfgMapped))
    else $error("warning shown while not mapped");

endmodule

/* File: include/fmeh_pkg.sv */
package fmeh_pkg;

  // clock and timing
  localparam longint CLK_HZ           = 40_000_000;
  localparam longint TEST_TIME_S      = 40;
  localparam longint STOP_TIME_S      = 5;
  localparam longint HOUR_TIME_S      = 3600;
  localparam longint MINUTE_TIME_S    = 60;
  localparam int     CNT_W            = 40;
  localparam longint TEST_CYCLES      = TEST_TIME_S * CLK_HZ;
  localparam longint STOP_CYCLES      = STOP_TIME_S * CLK_HZ;
  localparam longint HOUR_CYCLES      = HOUR_TIME_S * CLK_HZ;
  localparam longint MINUTE_CYCLES    = MINUTE_TIME_S * CLK_HZ;

  // fan limits
  localparam logic [18:0] HOURS_MAX        = 19'h7a120;
  localparam logic [15:0] HOURS_LIMIT_DFLT = 16'hafc8;
  localparam logic [15:0] RPM_NORMAL_LIMIT = 16'h0bb8;
  localparam logic [15:0] RPM_MIN_LIMIT    = 16'h0190;
  localparam logic [15:0] RPM_STOP_LIMIT   = 16'h0032;

  // register offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CFG     = 8'h04;
  localparam logic [7:0] OFS_HLIMIT  = 8'h08;
  localparam logic [7:0] OFS_SUMMARY = 8'h0c;
  localparam logic [7:0] OFS_COND    = 8'h10;
  localparam logic [7:0] OFS_TEST    = 8'h14;
  localparam logic [7:0] OFS_HOURS0  = 8'h18;
  localparam logic [7:0] OFS_RPM0    = 8'h24;
  localparam logic [7:0] OFS_STATUS  = 8'h30;

  // field positions
  localparam int CTRL_START_POS = 0;
  localparam int CTRL_CLR_POS   = 1;
  localparam int CFG_SRC_POS    = 0;
  localparam int CFG_RESP_POS   = 2;
  localparam int CFG_AUTO_POS   = 5;
  localparam int CFG_LIMIT_POS  = 6;
  localparam int CFG_MAP_POS    = 9;
  localparam int CFG_W          = 10;
  localparam int TEST_BUSY_POS  = 9;

  // external fault source
  localparam logic [1:0] SRC_NONE    = 2'h0;
  localparam logic [1:0] SRC_DI_HIGH = 2'h1;
  localparam logic [1:0] SRC_DI_LOW  = 2'h2;
  localparam logic [1:0] SRC_VIRTUAL = 2'h3;

  // external fault response
  localparam logic [2:0] RESP_IGNORE    = 3'h0;
  localparam logic [2:0] RESP_FREEWHEEL = 3'h1;
  localparam logic [2:0] RESP_CONFIG    = 3'h2;
  localparam logic [2:0] RESP_DECEL     = 3'h3;
  localparam logic [2:0] RESP_BRAKE     = 3'h4;

  // stop request to the sequencer
  localparam logic [2:0] STOP_NONE      = 3'h0;
  localparam logic [2:0] STOP_FREEWHEEL = 3'h1;
  localparam logic [2:0] STOP_CONFIG    = 3'h2;
  localparam logic [2:0] STOP_DECEL     = 3'h3;
  localparam logic [2:0] STOP_BRAKE     = 3'h4;

  // auto reset limit codes, minutes
  localparam logic [2:0] LIMIT_UNLIMITED = 3'h6;
  localparam logic [7:0] LIMIT_MINUTES [6] = '{8'h05, 8'h0a, 8'h1e, 8'h3c, 8'h78, 8'hb4};

  // fan condition and summary codes
  localparam logic [1:0] COND_OK    = 2'h0;
  localparam logic [1:0] COND_WARN  = 2'h1;
  localparam logic [1:0] COND_ERROR = 2'h2;
  localparam logic [3:0] SUM_UNDEF  = 4'h8;
  localparam logic [3:0] SUM_NA     = 4'h9;

  // reset values
  localparam logic [CFG_W-1:0] CFG_RESET = 10'h004;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP} fmeh_test_t;
  typedef enum logic [1:0] {EX_IDLE, EX_STOPPING, EX_FAULT, EX_LOCKED} fmeh_ext_t;

endpackage

/* File: hdl/fmeh_fan_hours.sv */
`timescale 1ns/10ps
module fmeh_fan_hours
  import fmeh_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOUR_CYC = CNT_W'(HOUR_CYCLES)
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // control
  input  wire logic        running,
  input  wire logic        clearReq,
  // count
  output logic      [18:0] hours
);

  logic [CNT_W-1:0] subCnt_r;
  logic [18:0]      hours_r;

  assign hours = hours_r;

  // running time within the current hour
  always_ff @(posedge clk_sys) begin
    if (rst || clearReq) begin
      subCnt_r <= '0;
    end else if (running) begin
      if (subCnt_r == HOUR_CYC - CNT_W'(1)) begin
        subCnt_r <= '0;
      end else begin
        subCnt_r <= subCnt_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || clearReq) begin
      hours_r <= '0;
    end else if (running && subCnt_r == HOUR_CYC - CNT_W'(1) && hours_r != HOURS_MAX) begin
      hours_r <= hours_r + 19'h1;
    end
  end

  chk_hours_clear: assert property (@(posedge clk_sys) disable iff (rst)
    clearReq |=> hours_r == 19'h0)
    else $error("hour counter not cleared");

  chk_hours_sat: assert property (@(posedge clk_sys) disable iff (rst)
    hours_r == HOURS_MAX && !clearReq |=> hours_r == HOURS_MAX)
    else $error("hour counter left its maximum");

endmodule

/* File: verif/fmeh_fan_model.sv */
`timescale 1ns/10ps
module fmeh_fan_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // drive and setup
  input  wire logic        fanOn,
  input  wire logic [2:0]  stuckMask,
  input  wire logic [15:0] spdOne,
  input  wire logic [15:0] spdTwo,
  input  wire logic [15:0] spdThree,
  // speed feedback
  output logic      [15:0] rpmOne,
  output logic      [15:0] rpmTwo,
  output logic      [15:0] rpmThree
);
  // a stuck fan keeps turning after it is switched off
  always_ff @(posedge clk_sys) begin
    rpmOne   <= (rst || !(fanOn || stuckMask[0])) ? 16'h0000 : spdOne;
    rpmTwo   <= (rst || !(fanOn || stuckMask[1])) ? 16'h0000 : spdTwo;
    rpmThree <= (rst || !(fanOn || stuckMask[2])) ? 16'h0000 : spdThree;
  end
endmodule

/* File: verif/tb_fan_monitor_and_error_handling.sv */
`timescale 1ns/10ps
module tb_fan_monitor_and_error_handling
  import fmeh_pkg::*;
;
  logic clk_sys = 1'h0, rst = 1'h1, regWe = 1'h0, regRe = 1'h0, fanDemand = 1'h0;
  logic starterStopped = 1'h0, extFaultPin = 1'h1, extFaultCmdBit = 1'h0;
  logic stopDone = 1'h0, manualReset = 1'h0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, rdv, regRdata;
  logic [15:0] spdOne = 16'h0dac, spdTwo = 16'h03e8, spdThree = 16'h0064;
  logic [15:0] fanOneRpm, fanTwoRpm, fanThreeRpm;
  logic [2:0]  stuck = 3'h4, stopType;
  logic        fanForceOn, fanFeedbackFault, faultRelay, extFaultWarnVisible;
  logic [2:0]  rsp [5] = '{RESP_IGNORE, RESP_FREEWHEEL, RESP_CONFIG, RESP_DECEL, RESP_BRAKE};
  logic [2:0]  stp [5] = '{STOP_NONE, STOP_FREEWHEEL, STOP_CONFIG, STOP_DECEL, STOP_BRAKE};
  logic [4:0]  rly = 5'h1a;
  int          error_cnt = 0, checks = 0, onCnt = 0;

  fmeh_fan_monitor #(.TEST_CYC(40'h14), .STOP_CYC(40'ha), .HOUR_CYC(40'h5),
    .MINUTE_CYC(40'ha)) u_fmeh_fan_monitor (.clk_sys(clk_sys), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe), .regRe(regRe),
    .regRdata(regRdata), .fanOneRpm(fanOneRpm), .fanTwoRpm(fanTwoRpm),
    .fanThreeRpm(fanThreeRpm), .fanDemand(fanDemand), .fanForceOn(fanForceOn),
    .fanFeedbackFault(fanFeedbackFault), .starterStopped(starterStopped),
    .extFaultPin(extFaultPin), .extFaultCmdBit(extFaultCmdBit), .stopDone(stopDone),
    .manualReset(manualReset), .stopType(stopType), .faultRelay(faultRelay),
    .extFaultWarnVisible(extFaultWarnVisible));
  fmeh_fan_model u_fmeh_fan_model (.clk_sys(clk_sys), .rst(rst),
    .fanOn(fanForceOn | fanDemand), .stuckMask(stuck), .spdOne(spdOne),
    .spdTwo(spdTwo), .spdThree(spdThree), .rpmOne(fanOneRpm), .rpmTwo(fanTwoRpm),
    .rpmThree(fanThreeRpm));

  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (fanForceOn === 1'h1) onCnt <= onCnt + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) begin
      regAddr <= a;
      regWdata <= d;
      regWe <= 1'h1;
    end
    @(posedge clk_sys) regWe <= 1'h0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys) begin
      regAddr <= a;
      regRe <= 1'h1;
    end
    @(posedge clk_sys) regRe <= 1'h0;
    #1 rdv = regRdata;
  endtask
  // one-cycle pulse on stop done (isStop) or on manual reset
  task pulse(input logic isStop);
    @(posedge clk_sys) begin
      stopDone <= isStop;
      manualReset <= !isStop;
    end
    @(posedge clk_sys) begin
      stopDone <= 1'h0;
      manualReset <= 1'h0;
    end
    tick(3);
  endtask
  function automatic logic [31:0] cfgw(logic [1:0] s, logic [2:0] r, logic a, logic m);
    return 32'({m, 3'h0, a, r, s});
  endfunction
  task wait_idle();
    for (int i = 0; i < 30; i++) begin
      rd(OFS_TEST);
      if (rdv[TEST_BUSY_POS] !== 1'h1) break;
    end
    chk(rdv[TEST_BUSY_POS], 32'h0, "test still busy");
  endtask

  task t_reset();
    rd(OFS_CFG);
    chk(rdv, 32'(CFG_RESET), "cfg reset value");
    wr(OFS_SUMMARY, 32'h3);
    rd(OFS_SUMMARY);
    chk(rdv, 32'(SUM_NA), "summary before evaluation");
    rd(8'hfc);
    chk(rdv, 32'h0, "unmapped read");
  endtask
  task t_test();
    wr(OFS_CTRL, 32'h1);
    tick(2);
    chk(fanForceOn, 32'h0, "start while running");
    @(posedge clk_sys) starterStopped <= 1'h1;
    wr(OFS_CTRL, 32'h1);
    rd(OFS_SUMMARY);
    chk(rdv, 32'(SUM_NA), "summary before first evaluation");
    wr(OFS_CTRL, 32'h1);
    wait_idle();
    chk(onCnt, 20, "forced run length");
    chk(rdv[8:0], 9'h188, "test flags");
    @(posedge clk_sys) begin
      stuck <= 3'h0;
      spdTwo <= 16'h0dac;
    end
    wr(OFS_CTRL, 32'h1);
    rd(OFS_TEST);
    chk(rdv[8:0], 9'h0, "flags cleared");
    rd(OFS_SUMMARY);
    chk(rdv, 32'(SUM_UNDEF), "summary in test");
    wait_idle();
    @(posedge clk_sys) spdTwo <= 16'h03e8;
  endtask
  task t_live();
    @(posedge clk_sys) fanDemand <= 1'h1;
    tick(4);
    rd(OFS_COND);
    chk(rdv[5:0], 6'h24, "fan conditions");
    rd(OFS_SUMMARY);
    chk(rdv, 32'h6, "summary fans 2 and 3");
    rd(OFS_RPM0 + 8'h4);
    chk(rdv, 32'h03e8, "fan two rpm");
  endtask
  task t_hours();
    wr(OFS_HLIMIT, 32'h3);
    for (int i = 0; i < 100 && fanFeedbackFault !== 1'h1; i++) tick(1);
    chk(fanFeedbackFault, 32'h1, "hours limit");
    @(posedge clk_sys) fanDemand <= 1'h0;
    tick(3);
    wr(OFS_CTRL, 32'h2);
    rd(OFS_HOURS0);
    chk(rdv, 32'h0, "fan one cleared");
    rd(OFS_HOURS0 + 8'h4);
    chk(32'(rdv >= 32'h3), 32'h1, "fan two kept");
    wr(OFS_CTRL, 32'hc);
    tick(3);
    chk(fanFeedbackFault, 32'h0, "fault after clear");
  endtask
  task t_src();
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CFG, cfgw(SRC_NONE, RESP_FREEWHEEL, 1'h0, 1'h0));
      // low active input idles high, so a cut cable shows as a fault
      @(posedge clk_sys) extFaultPin <= (i == 2);
      wr(OFS_CFG, cfgw(2'(i), RESP_FREEWHEEL, 1'h0, 1'h0));
      @(posedge clk_sys) begin
        extFaultPin <= (i != 2);
        extFaultCmdBit <= 1'h1;
      end
      tick(5);
      chk(faultRelay, 32'(i != 0), "source select");
      @(posedge clk_sys) begin
        extFaultPin <= (i == 2);
        extFaultCmdBit <= 1'h0;
      end
      tick(4);
      pulse(1'h0);
      chk(faultRelay, 32'h0, "manual reset");
    end
    @(posedge clk_sys) extFaultPin <= 1'h1;
  endtask
  task t_resp();
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CFG, cfgw(SRC_VIRTUAL, rsp[i], 1'h0, i == 2));
      @(posedge clk_sys) extFaultCmdBit <= 1'h1;
      tick(3);
      chk(stopType, 32'(stp[i]), "stop type");
      chk(faultRelay, 32'(i == 1), "relay before stop done");
      if (i == 0 || i == 2) chk(extFaultWarnVisible, 32'(i == 2), "warning");
      pulse(1'h1);
      @(posedge clk_sys) extFaultCmdBit <= 1'h0;
      tick(4);
      chk(faultRelay, 32'(rly[i]), "relay after stop");
      pulse(1'h0);
      chk(32'({faultRelay, stopType}), 32'h0, "back to normal");
    end
  endtask
  task t_auto();
    wr(OFS_CFG, cfgw(SRC_VIRTUAL, RESP_FREEWHEEL, 1'h1, 1'h0));
    @(posedge clk_sys) extFaultCmdBit <= 1'h1;
    tick(4);
    chk(32'({faultRelay, stopType}), 32'(STOP_FREEWHEEL), "relay held off");
    @(posedge clk_sys) extFaultCmdBit <= 1'h0;
    tick(4);
    chk(stopType, 32'(STOP_NONE), "self recovery");
    @(posedge clk_sys) extFaultCmdBit <= 1'h1;
    tick(40);
    chk(faultRelay, 32'h0, "inside time limit");
    tick(20);
    chk(faultRelay, 32'h1, "limit expired");
    @(posedge clk_sys) extFaultCmdBit <= 1'h0;
    tick(4);
    chk(faultRelay, 32'h1, "manual only");
    pulse(1'h0);
    chk(faultRelay, 32'h0, "manual clears");
  endtask

  task give_verdict();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
  initial begin
    tick(2);
    @(posedge clk_sys) rst <= 1'h0;
    t_reset();
    t_test();
    t_live();
    t_hours();
    t_src();
    t_resp();
    t_auto();
    give_verdict();
  end
endmodule
